// ---- src/rtc_trim_pkg.sv ----
// constants for the output, supply and trim control registers
package rtc_trim_pkg;
  // register offsets
  localparam logic [7:0] INT_CTRL_OFS   = 8'h08;
  localparam logic [7:0] SUPPLY_OFS     = 8'h09;
  localparam logic [7:0] BATT_TRIP_OFS  = 8'h0a;
  localparam logic [7:0] TRIM_OFS       = 8'h0b;
  // field positions
  localparam int FREQ_LSB      = 0;
  localparam int CLR_STAMP_BIT = 7;
  localparam int BROWN_LSB     = 0;
  localparam int RESEAL_BIT    = 6;
  localparam int ALARM1_LSB    = 3;
  localparam int ALARM2_LSB    = 0;
  localparam int ATRIM_LSB     = 0;
  localparam int DTRIM_LSB     = 6;
  // reset values
  localparam logic [3:0] FREQ_RST   = 4'h1;
  localparam logic [2:0] BROWN_RST  = 3'h0;
  localparam logic [2:0] ALARM1_RST = 3'h0;
  localparam logic [2:0] ALARM2_RST = 3'h0;
  // output rate codes
  localparam logic [3:0] FREQ_OFF     = 4'h0;
  localparam logic [3:0] FREQ_FULL    = 4'h1;
  localparam logic [3:0] FREQ_4096    = 4'h2;
  localparam logic [3:0] FREQ_1024    = 4'h3;
  localparam logic [3:0] FREQ_64      = 4'h4;
  localparam int         TAP_4096     = 2;
  localparam int         TAP_1024     = 4;
  localparam int         TAP_64       = 8;
  localparam int         DIV_WIDTH    = 20;
  // coarse digital trim codes
  localparam logic [1:0] DTRIM_OFF  = 2'h0;
  localparam logic [1:0] DTRIM_PLUS = 2'h1;
  localparam logic [1:0] DTRIM_ZERO = 2'h2;
  localparam logic [1:0] DTRIM_MIN  = 2'h3;
  // threshold tables in millivolts; 0 marks a reserved code
  localparam int TBL_BROWN  = 0;
  localparam int TBL_ALARM1 = 1;
  localparam int TBL_ALARM2 = 2;
  localparam logic [15:0] MV_RESERVED = 16'h0000;

  function automatic logic [15:0] trip_mv(input int tbl,
                                          input logic [2:0] code);
    logic [15:0] mv;
    mv = MV_RESERVED;
    if (tbl == TBL_BROWN) begin
      case (code)
        3'h0:    mv = 16'd2295;
        3'h1:    mv = 16'd2550;
        3'h2:    mv = 16'd2805;
        3'h3:    mv = 16'd3060;
        3'h4:    mv = 16'd4250;
        3'h5:    mv = 16'd4675;
        default: mv = MV_RESERVED;
      endcase
    end else if (tbl == TBL_ALARM1) begin
      case (code)
        3'h0:    mv = 16'd2125;
        3'h1:    mv = 16'd2295;
        3'h2:    mv = 16'd2550;
        3'h3:    mv = 16'd2805;
        3'h4:    mv = 16'd3060;
        3'h5:    mv = 16'd4250;
        3'h6:    mv = 16'd4675;
        default: mv = MV_RESERVED;
      endcase
    end else begin
      case (code)
        3'h0:    mv = 16'd1875;
        3'h1:    mv = 16'd2025;
        3'h2:    mv = 16'd2250;
        3'h3:    mv = 16'd2475;
        3'h4:    mv = 16'd2700;
        3'h5:    mv = 16'd3750;
        3'h6:    mv = 16'd4125;
        default: mv = MV_RESERVED;
      endcase
    end
    return mv;
  endfunction
endpackage

// ---- src/trip_compare.sv ----
// threshold lookup and below-level compare for one supply monitor
`timescale 1ns/1ps
module trip_compare #(
  parameter int TABLE = 0
) (
  // level select and measured voltage
  input  wire logic [2:0]  code_in,
  input  wire logic [15:0] level_mv_in,
  // result
  output logic             below_out
);
  import rtc_trim_pkg::*;
  logic [15:0] thresh;

  // a reserved code never trips, so a bad write cannot raise a flag
  always_comb begin
    thresh    = trip_mv(TABLE, code_in);
    below_out = (thresh != MV_RESERVED) && (level_mv_in < thresh);
  end
endmodule

// ---- src/freq_out_gen.sv ----
// oscillator divider and rate select for the shared output pin
`timescale 1ns/1ps
module freq_out_gen #(
  parameter int WIDTH = rtc_trim_pkg::DIV_WIDTH
) (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  // oscillator pin and rate select
  input  wire logic       osc_clk_in,
  input  wire logic [3:0] freq_select_in,
  // square wave
  output logic            wave_out
);
  import rtc_trim_pkg::*;

  typedef struct packed {
    logic             sync1;
    logic             sync2;
    logic             prev;
    logic [WIDTH-1:0] count;
    logic             wave;
  } div_state_t;

  div_state_t state_reg;
  div_state_t state_next;
  int         tap;

  always_comb begin
    state_next       = state_reg;
    tap              = 0;
    state_next.sync1 = osc_clk_in;
    state_next.sync2 = state_reg.sync1;
    state_next.prev  = state_reg.sync2;
    // counts each rising oscillator edge; bit n halves 32768 Hz n+1 times
    if (state_reg.sync2 && !state_reg.prev) begin
      state_next.count = state_reg.count + 1'b1;
    end
    if (freq_select_in == FREQ_4096) begin
      tap = TAP_4096;
    end else if (freq_select_in == FREQ_1024) begin
      tap = TAP_1024;
    end else begin
      tap = TAP_64 + int'(freq_select_in) - int'(FREQ_64);
    end
    if (freq_select_in == FREQ_OFF) begin
      state_next.wave = 1'b1;
    end else if (freq_select_in == FREQ_FULL) begin
      state_next.wave = state_reg.sync2;
    end else begin
      state_next.wave = state_reg.count[tap];
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign wave_out = state_reg.wave;
endmodule

// ---- src/rtc_output_supply_trim_ctrl.sv ----
// output select, supply monitor thresholds, reseal and trim registers
`timescale 1ns/1ps
module rtc_output_supply_trim_ctrl (
  // clock and power-up reset
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  // register port from the serial interface
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [7:0]  reg_wdata_in,
  output logic [7:0]       reg_rdata_out,
  output logic             reg_hit_out,
  // oscillator and real time clock events
  input  wire logic        osc_clk_in,
  input  wire logic        seconds_59_in,
  input  wire logic        temp_sense_enable_in,
  input  wire logic        alarm_active_in,
  // supply state and measured levels
  input  wire logic        on_main_in,
  input  wire logic [15:0] vdd_mv_in,
  input  wire logic [15:0] vbat_mv_in,
  // factory trim store
  input  wire logic [7:0]  trim_preset_in,
  // shared interrupt and frequency pin, open drain
  output logic             irq_freq_pin_out,
  output logic             irq_freq_pin_oe_n_out,
  // monitor flags
  output logic             low_supply_flag_out,
  output logic             batt_alarm1_flag_out,
  output logic             batt_alarm2_flag_out,
  // stamp clear, battery switch and trim values
  output logic             clear_stamps_out,
  output logic             battery_disconnect_out,
  output logic [1:0]       coarse_digital_trim_out,
  output logic [5:0]       analog_trim_out
);
  import rtc_trim_pkg::*;

  typedef struct packed {
    logic [3:0] freq_select;
    logic [2:0] brownout_level_sel;
    logic [2:0] batt_alarm1_level;
    logic [2:0] batt_alarm2_level;
    logic       battery_disconnect;
    logic [7:0] trim;
    logic       trim_loaded;
    logic       clear_stamps;
    logic       low_supply_flag;
    logic       batt_alarm1_flag;
    logic       batt_alarm2_flag;
    logic       main_sync1;
    logic       main_sync2;
    logic       main_lost;
    logic       tse_prev;
    logic [7:0] rdata;
    logic       hit;
    logic       pin_low;
  } ctrl_state_t;

  ctrl_state_t state_reg;
  ctrl_state_t state_next;
  logic        wave;
  logic        vdd_below;
  logic        bat1_below;
  logic        bat2_below;
  logic        check_batt;
  logic        on_main;
  logic [7:0]  supply_view;
  logic [7:0]  batt_view;
  logic [7:0]  int_view;
  logic        sel_int;
  logic        sel_supply;
  logic        sel_batt;
  logic        sel_trim;
  logic        sel_any;
  logic        take_wr;
  logic        take_rd;
  logic        tse_rise;
  logic        freq_on;
  logic        main_back;

  freq_out_gen #(
    .WIDTH (DIV_WIDTH)
  ) u_freq (
    .clk_in         (clk_in),
    .reset_in       (reset_in),
    .osc_clk_in     (osc_clk_in),
    .freq_select_in (state_reg.freq_select),
    .wave_out       (wave)
  );

  trip_compare #(
    .TABLE (TBL_BROWN)
  ) u_brown (
    .code_in     (state_reg.brownout_level_sel),
    .level_mv_in (vdd_mv_in),
    .below_out   (vdd_below)
  );

  trip_compare #(
    .TABLE (TBL_ALARM1)
  ) u_alarm1 (
    .code_in     (state_reg.batt_alarm1_level),
    .level_mv_in (vbat_mv_in),
    .below_out   (bat1_below)
  );

  trip_compare #(
    .TABLE (TBL_ALARM2)
  ) u_alarm2 (
    .code_in     (state_reg.batt_alarm2_level),
    .level_mv_in (vbat_mv_in),
    .below_out   (bat2_below)
  );

  always_comb begin
    state_next = state_reg;
    on_main    = state_reg.main_sync2;
    // supply switch state comes from the analog side, so it is synchronised
    state_next.main_sync1 = on_main_in;
    state_next.main_sync2 = state_reg.main_sync1;
    state_next.tse_prev   = temp_sense_enable_in;
    state_next.clear_stamps = 1'b0;
    state_next.hit          = 1'b0;

    // preset store is sampled after reset release, never under reset
    if (!state_reg.trim_loaded) begin
      state_next.trim        = trim_preset_in;
      state_next.trim_loaded = 1'b1;
    end

    // read views; bits with no field read as zero
    supply_view                 = 8'h00;
    supply_view[BROWN_LSB +: 3] = state_reg.brownout_level_sel;
    batt_view                   = 8'h00;
    batt_view[RESEAL_BIT]       = state_reg.battery_disconnect;
    batt_view[ALARM1_LSB +: 3]  = state_reg.batt_alarm1_level;
    batt_view[ALARM2_LSB +: 3]  = state_reg.batt_alarm2_level;
    int_view                    = 8'h00;
    int_view[FREQ_LSB +: 4]     = state_reg.freq_select;

    // one select per mapped offset
    sel_int    = 1'b0;
    sel_supply = 1'b0;
    sel_batt   = 1'b0;
    sel_trim   = 1'b0;
    if (reg_addr_in == INT_CTRL_OFS) begin
      sel_int = 1'b1;
    end else if (reg_addr_in == SUPPLY_OFS) begin
      sel_supply = 1'b1;
    end else if (reg_addr_in == BATT_TRIP_OFS) begin
      sel_batt = 1'b1;
    end else if (reg_addr_in == TRIM_OFS) begin
      sel_trim = 1'b1;
    end
    sel_any = sel_int || sel_supply || sel_batt || sel_trim;
    // a write in the same cycle wins over a read
    take_wr = reg_wr_in;
    take_rd = reg_rd_in && !reg_wr_in;

    // register writes
    if (take_wr && sel_int) begin
      state_next.freq_select = reg_wdata_in[FREQ_LSB +: 4];
    end
    if (take_wr && sel_supply) begin
      state_next.clear_stamps = reg_wdata_in[CLR_STAMP_BIT];
      state_next.brownout_level_sel =
        reg_wdata_in[BROWN_LSB +: 3];
    end
    if (take_wr && sel_batt) begin
      state_next.battery_disconnect = reg_wdata_in[RESEAL_BIT];
      state_next.batt_alarm1_level =
        reg_wdata_in[ALARM1_LSB +: 3];
      state_next.batt_alarm2_level =
        reg_wdata_in[ALARM2_LSB +: 3];
    end
    // a trim write earns a hit and nothing else: the trim is read only

    // register reads; an unmapped offset reads zero with no hit
    if (take_rd) begin
      if (sel_int) begin
        state_next.rdata = int_view;
      end else if (sel_supply) begin
        state_next.rdata = supply_view;
      end else if (sel_batt) begin
        state_next.rdata = batt_view;
      end else if (sel_trim) begin
        state_next.rdata = state_reg.trim;
      end else begin
        state_next.rdata = 8'h00;
      end
    end
    state_next.hit = (take_wr || take_rd) && sel_any;

    // a main supply loss followed by its return clears the reseal bit
    main_back = on_main && state_reg.main_lost;
    if (!on_main) begin
      state_next.main_lost = 1'b1;
    end else if (main_back) begin
      state_next.main_lost          = 1'b0;
      state_next.battery_disconnect = 1'b0;
    end

    // brownout is live on main supply and cleared otherwise
    state_next.low_supply_flag = on_main && vdd_below;

    // battery flags only move on a check, then hold to the next one
    tse_rise   = temp_sense_enable_in && !state_reg.tse_prev;
    check_batt = on_main && (seconds_59_in || tse_rise);
    if (check_batt) begin
      state_next.batt_alarm1_flag = bat1_below;
      state_next.batt_alarm2_flag = bat2_below;
    end

    // frequency mode wins the shared pin; alarm drives it only when off
    freq_on = (state_reg.freq_select != FREQ_OFF);
    if (freq_on) begin
      state_next.pin_low = !wave;
    end else begin
      state_next.pin_low = alarm_active_in;
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      // field by field, so each power-up value stands in plain sight
      state_reg.freq_select        <= FREQ_RST;
      state_reg.brownout_level_sel <= BROWN_RST;
      state_reg.batt_alarm1_level  <= ALARM1_RST;
      state_reg.batt_alarm2_level  <= ALARM2_RST;
      state_reg.battery_disconnect <= 1'b0;
      state_reg.trim               <= 8'h00;
      state_reg.trim_loaded        <= 1'b0;
      state_reg.clear_stamps       <= 1'b0;
      state_reg.low_supply_flag    <= 1'b0;
      state_reg.batt_alarm1_flag   <= 1'b0;
      state_reg.batt_alarm2_flag   <= 1'b0;
      state_reg.main_sync1         <= 1'b0;
      state_reg.main_sync2         <= 1'b0;
      state_reg.main_lost          <= 1'b0;
      state_reg.tse_prev           <= 1'b0;
      state_reg.rdata              <= 8'h00;
      state_reg.hit                <= 1'b0;
      state_reg.pin_low            <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // trim fields only leave the block; the oscillator applies them by
  // pulse skipping (coarse) and load capacitance (fine)
  assign coarse_digital_trim_out = state_reg.trim[DTRIM_LSB +: 2];
  assign analog_trim_out         = state_reg.trim[ATRIM_LSB +: 6];

  // register port answers
  assign reg_rdata_out           = state_reg.rdata;
  assign reg_hit_out             = state_reg.hit;

  // open drain: data held low, the enable alone does the signalling
  assign irq_freq_pin_out        = 1'b0;
  assign irq_freq_pin_oe_n_out   = !state_reg.pin_low;

  // monitor flags and supply controls
  assign low_supply_flag_out     = state_reg.low_supply_flag;
  assign batt_alarm1_flag_out    = state_reg.batt_alarm1_flag;
  assign batt_alarm2_flag_out    = state_reg.batt_alarm2_flag;
  assign clear_stamps_out        = state_reg.clear_stamps;
  assign battery_disconnect_out  = state_reg.battery_disconnect;
endmodule

// ---- verif/rtc_ctrl_monitor.sv ----
// assertions on the register port, monitor flags, reseal and trim
`timescale 1ns/1ps
module rtc_ctrl_monitor
  import rtc_trim_pkg::*;
(
  // watched ports
  input wire logic        clk_in,
  input wire logic        reset_in,
  input wire logic [7:0]  reg_addr_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [7:0]  reg_wdata_in,
  input wire logic [7:0]  reg_rdata_out,
  input wire logic        reg_hit_out,
  input wire logic        seconds_59_in,
  input wire logic        temp_sense_enable_in,
  input wire logic        on_main_in,
  input wire logic        low_supply_flag_out,
  input wire logic        batt_alarm1_flag_out,
  input wire logic        batt_alarm2_flag_out,
  input wire logic        clear_stamps_out,
  input wire logic        battery_disconnect_out,
  input wire logic [1:0]  coarse_digital_trim_out,
  input wire logic [5:0]  analog_trim_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  logic rd_ok;
  assign rd_ok = reg_rd_in && !reg_wr_in;
  // four samples cover the two-stage supply sync plus the flag register
  sequence s_off; !on_main_in [*4]; endsequence
  sequence s_on; (on_main_in && !reg_wr_in) [*4]; endsequence
  sequence s_clr;
    reg_wr_in && reg_addr_in == SUPPLY_OFS && reg_wdata_in[CLR_STAMP_BIT];
  endsequence
  a_hit_mapped: assert property (
    (reg_wr_in || reg_rd_in) && reg_addr_in[7:2] == 6'h02 |=> reg_hit_out)
    else $error("no hit on a mapped offset");
  a_clear_pulse: assert property (s_clr |=> clear_stamps_out)
    else $error("stamp clear pulse missing");
  a_clear_cause: assert property (
    clear_stamps_out |-> $past(reg_wr_in && reg_addr_in == SUPPLY_OFS
    && reg_wdata_in[CLR_STAMP_BIT])) else $error("stray stamp clear");
  a_supply_zeros: assert property (
    rd_ok && reg_addr_in == SUPPLY_OFS |=> reg_rdata_out[7:3] == 5'h00)
    else $error("supply register upper bits not zero");
  a_reseal_read: assert property (
    rd_ok && reg_addr_in == BATT_TRIP_OFS |=> !reg_rdata_out[7]
    && reg_rdata_out[6] == $past(battery_disconnect_out))
    else $error("reseal readback wrong");
  a_reseal_set: assert property (
    reg_wr_in && reg_addr_in == BATT_TRIP_OFS && reg_wdata_in[RESEAL_BIT]
    |=> battery_disconnect_out) else $error("reseal not set");
  a_reseal_clear: assert property (s_off ##1 s_on |=>
    !battery_disconnect_out) else $error("reseal kept over power cycle");
  a_low_off: assert property (s_off |-> !low_supply_flag_out)
    else $error("brownout flag set off main");
  a_batt_cause: assert property (
    $changed({batt_alarm1_flag_out, batt_alarm2_flag_out}) |->
    $past(seconds_59_in) || ($past(temp_sense_enable_in)
    && !$past(temp_sense_enable_in, 2)))
    else $error("battery flag moved without a check");
  a_trim_fixed: assert property (
    reg_wr_in && reg_addr_in == TRIM_OFS |=>
    $stable({coarse_digital_trim_out, analog_trim_out}))
    else $error("trim changed by a write");
endmodule

bind rtc_output_supply_trim_ctrl rtc_ctrl_monitor i_mon (.clk_in, .reset_in,
  .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in, .reg_rdata_out,
  .reg_hit_out, .seconds_59_in, .temp_sense_enable_in, .on_main_in,
  .low_supply_flag_out, .batt_alarm1_flag_out, .batt_alarm2_flag_out,
  .clear_stamps_out, .battery_disconnect_out, .coarse_digital_trim_out,
  .analog_trim_out);

// ---- verif/reg_host.sv ----
// host side of the register port: single byte writes and reads
`timescale 1ns/1ps
module reg_host (
  // clock
  input  wire logic       clk_in,
  // register port towards the device
  output logic [7:0]      addr_out,
  output logic            wr_out,
  output logic            rd_out,
  output logic [7:0]      wdata_out,
  input  wire logic [7:0] rdata_in,
  input  wire logic       hit_in
);
  initial begin
    addr_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
    wdata_out = 8'h00;
  end
  // trim writes are only issued with temp-sense enable low
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    output logic h);
    @(negedge clk_in);
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(negedge clk_in);
    wr_out = 1'b0;
    h = hit_in;
    // released lines carry the inverse so stale data never matches
    addr_out = ~a;
    wdata_out = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic h);
    @(negedge clk_in);
    addr_out = a;
    rd_out = 1'b1;
    @(negedge clk_in);
    rd_out = 1'b0;
    addr_out = ~a;
    d = rdata_in;
    h = hit_in;
  endtask
endmodule

// ---- verif/test_rtc_output_supply_trim_ctrl.sv ----
// self-checking bench for the output, supply and trim control registers
`timescale 1ns/1ps
module test_rtc_output_supply_trim_ctrl;
  import rtc_trim_pkg::*;
  localparam logic [7:0] PRESET = 8'h9a;
  logic        clk_in, reset_in, osc, s59, temp_sense_enable, alarm, on_main, wr, rd, h;
  logic        hit, low, b1, b2, disc, oe_n, oe_q, clr, pin;
  logic [7:0]  addr, wdata, rdata;
  logic [15:0] vdd, vbat;
  logic [1:0]  ctr;
  logic [5:0]  atr;
  int          fail_count, n_checks;
  int          edges = 0;
  int          cyc = 0;
  int brn[6] = '{2295, 2550, 2805, 3060, 4250, 4675};
  int al1[7] = '{2125, 2295, 2550, 2805, 3060, 4250, 4675};
  int al2[7] = '{1875, 2025, 2250, 2475, 2700, 3750, 4125};
  int lo[5] = '{0, 63, 7, 1, 0};
  int hi[5] = '{0, 65, 9, 3, 1};

  rtc_output_supply_trim_ctrl i_dut (.clk_in(clk_in), .reset_in(reset_in),
    .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_hit_out(hit),
    .osc_clk_in(osc), .seconds_59_in(s59), .temp_sense_enable_in(temp_sense_enable),
    .alarm_active_in(alarm), .on_main_in(on_main), .vdd_mv_in(vdd),
    .vbat_mv_in(vbat), .trim_preset_in(PRESET), .irq_freq_pin_out(pin),
    .irq_freq_pin_oe_n_out(oe_n), .low_supply_flag_out(low),
    .batt_alarm1_flag_out(b1), .batt_alarm2_flag_out(b2),
    .clear_stamps_out(clr), .battery_disconnect_out(disc),
    .coarse_digital_trim_out(ctr), .analog_trim_out(atr));
  reg_host i_host (.clk_in(clk_in), .addr_out(addr), .wr_out(wr),
    .rd_out(rd), .wdata_out(wdata), .rdata_in(rdata), .hit_in(hit));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // oscillator shortened to 32 clocks a period so rates show in a short run
  initial begin
    osc = 1'b0;
    forever #160 osc = ~osc;
  end
  always @(posedge clk_in) begin
    oe_q <= oe_n;
    if (oe_q !== oe_n) edges <= edges + 1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic give_verdict;
    if (fail_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_range(input int got, input int l, input int u);
    n_checks++;
    if (got < l || got > u) begin
      fail_count++;
      $display("wrong value at %0t: %0d pin edges", $time, got);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e,
                       input logic eh);
    logic [7:0] d;
    logic       g;
    i_host.rd(a, d, g);
    chk(d, e);
    chk({7'h0, g}, {7'h0, eh});
  endtask
  task automatic trig(input bit t);
    if (t) temp_sense_enable = 1'b1;
    else s59 = 1'b1;
    idle(1);
    s59 = 1'b0;
    temp_sense_enable = 1'b0;
    idle(2);
  endtask
  task automatic measure(input int c);
    int e0;
    idle(8);
    e0 = edges;
    idle(1024);
    chk_range(edges - e0, lo[c], hi[c]);
  endtask

  initial begin
    reset_in = 1'b1;
    {s59, temp_sense_enable, alarm, on_main} = 4'h1;
    vdd = 16'hffff;
    vbat = 16'hffff;
    {fail_count, n_checks} = '0;
    idle(2);
    reset_in = 1'b0;
    idle(2);
    measure(1);
    rdchk(INT_CTRL_OFS, {4'h0, FREQ_RST}, 1'b1);
    rdchk(SUPPLY_OFS, 8'h00, 1'b1);
    rdchk(BATT_TRIP_OFS, 8'h00, 1'b1);
    chk({ctr, atr}, PRESET);
    i_host.wr(TRIM_OFS, ~PRESET, h);
    chk({7'h0, h}, 8'h01);
    rdchk(TRIM_OFS, PRESET, 1'b1);
    rdchk(8'h0c, 8'h00, 1'b0);
    i_host.wr(8'h0c, 8'hff, h);
    chk({7'h0, h}, 8'h00);
    i_host.wr(SUPPLY_OFS, 8'hfd, h);
    chk({6'h0, clr, h}, 8'h03);
    rdchk(SUPPLY_OFS, 8'h05, 1'b1);
    chk({7'h0, clr}, 8'h00);
    i_host.wr(BATT_TRIP_OFS, 8'hf6, h);
    rdchk(BATT_TRIP_OFS, 8'h76, 1'b1);
    chk({7'h0, disc}, 8'h01);
    for (int c = 0; c < 8; c++) begin
      i_host.wr(SUPPLY_OFS, 8'(c), h);
      vdd = (c < 6) ? 16'(brn[c] - 1) : 16'h0000;
      idle(2);
      chk({7'h0, low}, {7'h0, c < 6});
      vdd = (c < 6) ? 16'(brn[c]) : 16'h0000;
      idle(2);
      chk({7'h0, low}, 8'h00);
    end
    for (int c = 0; c < 8; c++) begin
      i_host.wr(BATT_TRIP_OFS, {2'b00, 3'(c), 3'(c)}, h);
      vbat = (c < 7) ? 16'(al1[c] - 1) : 16'h0000;
      trig(1'b0);
      chk({6'h0, b1, b2}, {6'h0, c < 7, 1'b0});
      vbat = (c < 7) ? 16'(al2[c] - 1) : 16'h0000;
      trig(1'b1);
      chk({6'h0, b1, b2}, (c < 7) ? 8'h03 : 8'h00);
      vbat = 16'hffff;
      idle(4);
      chk({6'h0, b1, b2}, (c < 7) ? 8'h03 : 8'h00);
      trig(1'b0);
      chk({6'h0, b1, b2}, 8'h00);
    end
    i_host.wr(BATT_TRIP_OFS, 8'h40, h);
    chk({7'h0, disc}, 8'h01);
    on_main = 1'b0;
    vdd = 16'h0000;
    vbat = 16'h0000;
    idle(6);
    chk({7'h0, low}, 8'h00);
    trig(1'b0);
    chk({6'h0, b1, b2}, 8'h00);
    on_main = 1'b1;
    vdd = 16'hffff;
    idle(6);
    chk({7'h0, disc}, 8'h00);
    alarm = 1'b1;
    for (int c = 0; c < 5; c++) begin
      i_host.wr(INT_CTRL_OFS, 8'(c), h);
      measure(c);
    end
    i_host.wr(INT_CTRL_OFS, {4'h0, FREQ_OFF}, h);
    idle(2);
    chk({7'h0, oe_n}, 8'h00);
    alarm = 1'b0;
    idle(2);
    chk({7'h0, oe_n}, 8'h01);
    chk({7'h0, pin}, 8'h00);
    // a second power-up in mid-run: reseal cleared, rate back to full
    i_host.wr(BATT_TRIP_OFS, 8'h40, h);
    chk({7'h0, disc}, 8'h01);
    reset_in = 1'b1;
    idle(2);
    reset_in = 1'b0;
    idle(2);
    chk({7'h0, disc}, 8'h00);
    rdchk(INT_CTRL_OFS, {4'h0, FREQ_RST}, 1'b1);
    chk({ctr, atr}, PRESET);
    give_verdict();
  end
endmodule
